// file: hdl/acs_pkg.sv
// Package for the converter conversion sequencer: timing constants, rates, commands, states.
// Assumes a 50 MHz ref_clk; converter timings are given for a 4.096 MHz system clock.
package acs_pkg;

  localparam int unsigned REF_CLK_HZ = 50000000;
  localparam int unsigned SYS_CLK_HZ = 4096000;

  // Power-on hold in system clock cycles.
  localparam int unsigned POR_SYS_CYCLES = 65536;

  // Reset-pin release hold time.
  localparam int unsigned RST_HOLD_US = 600;
  localparam int unsigned RST_HOLD_CYCLES = (RST_HOLD_US * (REF_CLK_HZ / 1000)) / 1000;

  // Filter hold after a start edge, in modulator clocks.
  localparam int unsigned FLT_HOLD_MOD_CYCLES = 32;

  // Single-shot conversion times, microseconds at 4.096 MHz, for each rate code 0..9.
  localparam int unsigned CONV_US_5 = 200295;
  localparam int unsigned CONV_US_10 = 100644;
  localparam int unsigned CONV_US_20 = 50825;
  localparam int unsigned CONV_US_40 = 25169;
  localparam int unsigned CONV_US_80 = 12716;
  localparam int unsigned CONV_US_160 = 6489;
  localparam int unsigned CONV_US_320 = 3247;
  localparam int unsigned CONV_US_640 = 1692;
  localparam int unsigned CONV_US_1000 = 1138;
  localparam int unsigned CONV_US_2000 = 575;

  // System clocks per modulator clock for each rate group.
  localparam int unsigned MOD_DIV_SLOW = 128;
  localparam int unsigned MOD_DIV_MID = 32;
  localparam int unsigned MOD_DIV_FAST = 16;
  localparam int unsigned MOD_DIV_MAX = 8;

  localparam logic [3:0] RATE_CODE_MAX = 4'h9;

  // Reference-control field codes: 00 off always, 01 on always, 1x on only while converting (here 1x is on in every state but power-down).
  localparam logic [1:0] REF_ALWAYS_ON = 2'h1;

  typedef enum logic [1:0] {
    ACS_CMD_NONE,
    ACS_CMD_RESET,
    ACS_CMD_SLEEP,
    ACS_CMD_WAKE
  } acs_cmd_t;

  typedef enum {
    ACS_ST_POR,
    ACS_ST_RST_HOLD,
    ACS_ST_POWER_DOWN,
    ACS_ST_FILTER_HOLD,
    ACS_ST_CONVERT
  } acs_state_t;

  // Host-side command strobe with its code.
  typedef struct packed {
    logic valid;
    acs_cmd_t code;
  } acs_cmd_req_t;

  // Configuration held in the device's registers that this block reads.
  typedef struct packed {
    logic [3:0] rate_code;
    logic [1:0] reference_control_bits;
    logic ready_on_data_out_select;
  } acs_cfg_t;

  // Status reported to the rest of the device.
  typedef struct packed {
    logic powered_down;
    logic filter_reset;
    logic regs_reset;
    logic spi_allowed;
    logic reference_on;
    logic clock_sel_internal;
  } acs_status_t;

endpackage : acs_pkg

// file: hdl/acs_pin_sync.sv
// Two-flop synchroniser with edge detection on the second stage.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module acs_pin_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
      last_reg <= RESET_VALUE;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule // acs_pin_sync

// file: hdl/acs_sequencer.sv
// Conversion sequencer: power-on hold, reset pin and command, power-down, start-pin conversions.
// Assumes a 50 MHz ref_clk; reset_n_pin and start_pin come from outside and are synchronised.
//
// Function
// - Hold all digital logic in reset for 2^16 system clocks after supply comes up.
// - Reset pin low resets at once, defaults registers, holds reset while low.
// - After reset pin rises, hold filter and registers reset 0.6 ms, then convert if start is high, else power down.
// - Reset pin low returns clock selection to the internal oscillator.
// - Reset command acts exactly like the reset pin.
// - Enter power-down on the sleep command or start pin low.
// - In power-down the reference follows the reference-control bits.
// - A high start pulse begins a new conversion.
// - Conversion end drives data ready low, and on data out when selected.
// - After a start-pulse conversion the device powers down automatically.
// - Results readable in power-down; start must go high before configuration access (spi_allowed here ignores the start pin).
// - Stay powered down until the start pin goes high again.
// - On start rise hold the decimation filter reset for 32 modulator clocks.
// - While start stays high, convert continuously.
// - Single-shot times: 200.295 ms at 5, 100.644 at 10, 50.825 at 20 SPS.
// - The power-up command powers up and begins a conversion like start rising.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int unsigned POR_CYCLES = (POR_SYS_CYCLES / (SYS_CLK_HZ / 1000)) * (REF_CLK_HZ / 1000)
    + ((POR_SYS_CYCLES % (SYS_CLK_HZ / 1000)) * (REF_CLK_HZ / 1000) + (SYS_CLK_HZ / 1000) - 1)
    / (SYS_CLK_HZ / 1000),
  parameter int unsigned RST_CYCLES = RST_HOLD_CYCLES,
  parameter int unsigned TIME_DIV = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reset_n_pin,
  input wire logic start_pin,
  input wire acs_pkg::acs_cmd_req_t cmd,
  input wire acs_pkg::acs_cfg_t cfg,
  input wire logic data_out_bit,
  input wire logic result_read,
  output logic data_ready_n,
  output logic shared_data_out_ready,
  output logic conv_done,
  output acs_pkg::acs_status_t status
);
  import acs_pkg::*;

  localparam int unsigned CNT_W = 32;

  acs_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic single_shot_reg;
  logic clk_internal_reg;
  logic data_ready_n_n_reg;
  logic dout_reg;
  logic done_reg;
  logic start_level;
  logic start_rise;
  logic start_fall;
  logic rst_level;
  logic rst_rise;
  logic soft_reset;
  logic any_reset;

  // Cycles of ref_clk for a time in microseconds, rounded down, at least one.
  function automatic logic [CNT_W-1:0] us_to_cycles(input int unsigned us);
    longint unsigned c;
    c = (longint'(us) * longint'(REF_CLK_HZ / 1000000)) / longint'(TIME_DIV);
    if (c == 0)
      c = 1;
    return c[CNT_W-1:0];
  endfunction

  // Single-shot conversion time for a rate code.
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [3:0] code);
    case (code)
      4'h0: return us_to_cycles(CONV_US_5);
      4'h1: return us_to_cycles(CONV_US_10);
      4'h2: return us_to_cycles(CONV_US_20);
      4'h3: return us_to_cycles(CONV_US_40);
      4'h4: return us_to_cycles(CONV_US_80);
      4'h5: return us_to_cycles(CONV_US_160);
      4'h6: return us_to_cycles(CONV_US_320);
      4'h7: return us_to_cycles(CONV_US_640);
      4'h8: return us_to_cycles(CONV_US_1000);
      default: return us_to_cycles(CONV_US_2000);
    endcase
  endfunction

  // Filter hold of 32 modulator clocks in ref_clk cycles for a rate code.
  function automatic logic [CNT_W-1:0] filter_hold_cycles(input logic [3:0] code);
    longint unsigned sys;
    longint unsigned c;
    if (code <= 4'h2)
      sys = longint'(FLT_HOLD_MOD_CYCLES * MOD_DIV_SLOW);
    else if (code <= 4'h5)
      sys = longint'(FLT_HOLD_MOD_CYCLES * MOD_DIV_MID);
    else if (code < RATE_CODE_MAX)
      sys = longint'(FLT_HOLD_MOD_CYCLES * MOD_DIV_FAST);
    else
      sys = longint'(FLT_HOLD_MOD_CYCLES * MOD_DIV_MAX);
    c = (sys * longint'(REF_CLK_HZ) + longint'(SYS_CLK_HZ) - 1) / longint'(SYS_CLK_HZ);
    return c[CNT_W-1:0];
  endfunction

  acs_pin_sync #(
    .RESET_VALUE(1'b0)
  ) u_start_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(start_pin),
    .level(start_level),
    .rise(start_rise),
    .fall(start_fall)
  );

  acs_pin_sync #(
    .RESET_VALUE(1'b1)
  ) u_reset_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin(reset_n_pin),
    .level(rst_level),
    .rise(rst_rise),
    .fall()
  );

  assign soft_reset = cmd.valid && (cmd.code == ACS_CMD_RESET);
  assign any_reset = ~rst_level | soft_reset;

  // Main sequencing: reset holds, power-down, filter hold and conversion timing.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ACS_ST_POR;
      cnt_reg <= '0;
      single_shot_reg <= 1'b0;
    end else if (state_reg == ACS_ST_POR) begin
      if (cnt_reg >= CNT_W'(POR_CYCLES - 1)) begin
        state_reg <= ACS_ST_RST_HOLD;
        cnt_reg <= CNT_W'(RST_CYCLES - 1);
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end else if (any_reset) begin
      state_reg <= ACS_ST_RST_HOLD;
      cnt_reg <= CNT_W'(RST_CYCLES - 1);
      single_shot_reg <= 1'b0;
    end else begin
      case (state_reg)
        ACS_ST_RST_HOLD: begin
          if (cnt_reg == '0) begin
            state_reg <= start_level ? ACS_ST_FILTER_HOLD : ACS_ST_POWER_DOWN;
            cnt_reg <= filter_hold_cycles(cfg.rate_code) - 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ACS_ST_POWER_DOWN: begin
          if (start_rise || (cmd.valid && cmd.code == ACS_CMD_WAKE)) begin
            state_reg <= ACS_ST_FILTER_HOLD;
            cnt_reg <= filter_hold_cycles(cfg.rate_code) - 1'b1;
            single_shot_reg <= 1'b0;
          end
        end
        ACS_ST_FILTER_HOLD, ACS_ST_CONVERT: begin
          // A low start pin ends continuous mode; the running conversion still finishes.
          if (start_fall)
            single_shot_reg <= 1'b1;
          if (cmd.valid && cmd.code == ACS_CMD_SLEEP) begin
            state_reg <= ACS_ST_POWER_DOWN;
          end else if (state_reg == ACS_ST_FILTER_HOLD) begin
            if (cnt_reg == '0) begin
              state_reg <= ACS_ST_CONVERT;
              cnt_reg <= conv_cycles(cfg.rate_code) - filter_hold_cycles(cfg.rate_code)
                - 1'b1;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end else if (cnt_reg == '0) begin
            if (single_shot_reg || !start_level) begin
              state_reg <= ACS_ST_POWER_DOWN;
            end else begin
              cnt_reg <= conv_cycles(cfg.rate_code) - 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= ACS_ST_POR;
      endcase
    end
  end

  // Completion pulse when the conversion counter expires.
  always_ff @(posedge ref_clk) begin
    if (srst)
      done_reg <= 1'b0;
    else
      done_reg <= !any_reset && state_reg == ACS_ST_CONVERT && cnt_reg == '0
        && !(cmd.valid && cmd.code == ACS_CMD_SLEEP);
  end

  // Data ready falls at completion and rises once the result is read or a filter hold begins.
  always_ff @(posedge ref_clk) begin
    if (srst || any_reset || state_reg == ACS_ST_POR) begin
      data_ready_n_n_reg <= 1'b1;
    end else if (done_reg) begin
      data_ready_n_n_reg <= 1'b0;
    end else if (result_read || state_reg == ACS_ST_FILTER_HOLD) begin
      data_ready_n_n_reg <= 1'b1;
    end
  end

  // Shared pin shows ready when selected, otherwise the serial data bit.
  always_ff @(posedge ref_clk) begin
    if (srst)
      dout_reg <= 1'b1;
    else if (cfg.ready_on_data_out_select && !result_read)
      dout_reg <= data_ready_n_n_reg & ~done_reg;
    else
      dout_reg <= data_out_bit;
  end

  // Clock-source selection returns to the internal oscillator on any reset.
  always_ff @(posedge ref_clk) begin
    if (srst || any_reset)
      clk_internal_reg <= 1'b1;
    else
      clk_internal_reg <= clk_internal_reg;
  end

  assign data_ready_n = data_ready_n_n_reg;
  assign shared_data_out_ready = dout_reg;
  assign conv_done = done_reg;

  always_comb begin
    status.powered_down = (state_reg == ACS_ST_POWER_DOWN);
    status.filter_reset = (state_reg != ACS_ST_CONVERT) || any_reset;
    status.regs_reset = (state_reg == ACS_ST_POR) || (state_reg == ACS_ST_RST_HOLD) || any_reset;
    // Serial access opens after the holds; the start pin does not gate it, in power-down or elsewhere.
    status.spi_allowed = !status.regs_reset;
    status.reference_on = (state_reg == ACS_ST_POWER_DOWN)
      ? (cfg.reference_control_bits == REF_ALWAYS_ON)
      : (cfg.reference_control_bits != 2'h0);
    status.clock_sel_internal = clk_internal_reg;
  end
endmodule // acs_sequencer

// file: verification/acs_host_model.sv
// Host controller model: drives the start pin and reads each result.
// Assumes start_req comes from the bench; reads wait for spi_allowed.
`timescale 1ns/1ps
module acs_host_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start_req,
  input wire logic slow,
  input wire logic data_ready_n,
  input wire logic spi_allowed,
  output logic start_pin,
  output logic result_read
);
  logic [4:0] wait_reg;
  always_ff @(posedge ref_clk) begin
    start_pin <= srst ? 1'b0 : start_req;
  end
  // A slow host leaves the result waiting, so data ready must stand meanwhile.
  always_ff @(posedge ref_clk) begin
    result_read <= 1'b0;
    if (srst || data_ready_n || !spi_allowed || result_read) begin
      wait_reg <= 5'h0;
    end else if (wait_reg == (slow ? 5'h14 : 5'h2)) begin
      result_read <= 1'b1;
      wait_reg <= 5'h0;
    end else begin
      wait_reg <= wait_reg + 5'h1;
    end
  end
endmodule // acs_host_model

// file: verification/acs_sequencer_sva.sv
// Checker for the conversion sequencer, bound to every acs_sequencer.
// Assumes both pins pass a two-stage synchroniser, so they act two cycles late.
`timescale 1ns/1ps
module acs_sequencer_sva
  import acs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reset_n_pin,
  input wire logic start_pin,
  input wire acs_pkg::acs_cmd_req_t cmd,
  input wire acs_pkg::acs_cfg_t cfg,
  input wire logic data_out_bit,
  input wire logic result_read,
  input wire logic data_ready_n,
  input wire logic shared_data_out_ready,
  input wire logic conv_done,
  input wire acs_pkg::acs_status_t status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence start_seen_s;
    $rose(start_pin) && status.powered_down && status.spi_allowed;
  endsequence
  sequence hold_seen_s;
    ##3 (status.filter_reset && !status.powered_down) [*8];
  endsequence
  por_hold_a: assert property ($fell(srst) |-> !status.spi_allowed [*8])
    else $error("serial access allowed during power-on hold");
  pin_reset_a: assert property (!reset_n_pin [*3]
    |-> status.regs_reset && !status.spi_allowed)
    else $error("reset pin low without reset");
  release_hold_a: assert property ($rose(reset_n_pin) |-> ##2 !status.spi_allowed [*8])
    else $error("reset hold ended too soon");
  clock_internal_a: assert property (!reset_n_pin [*3] |-> status.clock_sel_internal)
    else $error("clock selection not internal in reset");
  cmd_reset_a: assert property (cmd.valid && cmd.code == ACS_CMD_RESET
    && status.spi_allowed |=> status.regs_reset)
    else $error("reset command ignored");
  sleep_entry_a: assert property (cmd.valid && cmd.code == ACS_CMD_SLEEP
    && status.spi_allowed && !status.powered_down |-> ##[1:2] status.powered_down)
    else $error("sleep command ignored");
  ref_pd_a: assert property (status.powered_down
    |-> status.reference_on == (cfg.reference_control_bits == REF_ALWAYS_ON))
    else $error("reference state wrong in power-down");
  ready_low_a: assert property (conv_done |=> !data_ready_n)
    else $error("data ready not low after completion");
  ready_cause_a: assert property ($fell(data_ready_n) |-> $past(conv_done))
    else $error("data ready fell without completion");
  shared_ready_a: assert property (conv_done && cfg.ready_on_data_out_select
    && !result_read |=> !shared_data_out_ready)
    else $error("shared pin shows no completion");
  filter_hold_a: assert property (start_seen_s |-> hold_seen_s)
    else $error("filter not held after start rise");
  wake_cmd_a: assert property (cmd.valid && cmd.code == ACS_CMD_WAKE
    && status.powered_down && status.spi_allowed |=> !status.powered_down && status.filter_reset)
    else $error("power-up command ignored");
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva u_sva (.ref_clk, .srst, .reset_n_pin, .start_pin, .cmd,
  .cfg, .data_out_bit, .result_read, .data_ready_n, .shared_data_out_ready, .conv_done,
  .status);

// file: verification/testbench.sv
// Self-checking bench for the conversion sequencer with a host model on its pins.
// Assumes shortened holds and conversion times divided by TDIV.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin #1; total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module testbench;
  import acs_pkg::*;
  localparam int TDIV = 4;
  localparam int RST = 30;
  localparam int T = CONV_US_2000 * (REF_CLK_HZ / 1000000) / TDIV;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic reset_n_pin = 1'b1;
  logic start_req = 1'b0;
  logic slow = 1'b1;
  logic data_out_bit = 1'b0;
  acs_cmd_req_t cmd = '{valid: 1'b0, code: ACS_CMD_NONE};
  acs_cfg_t cfg = '{rate_code: RATE_CODE_MAX, reference_control_bits: 2'h0,
    ready_on_data_out_select: 1'b1};
  logic start_pin, result_read, data_ready_n, shared, conv_done;
  acs_status_t status;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) data_out_bit <= ~data_out_bit;
  acs_sequencer #(.POR_CYCLES(64), .RST_CYCLES(RST), .TIME_DIV(TDIV)) uut (.ref_clk, .srst,
    .reset_n_pin, .start_pin, .cmd, .cfg, .data_out_bit, .result_read, .data_ready_n,
    .shared_data_out_ready(shared), .conv_done, .status);
  acs_host_model u_host (.ref_clk, .srst, .start_req, .slow, .data_ready_n,
    .spi_allowed(status.spi_allowed), .start_pin, .result_read);
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Waits for one of: 0 ready low, 1 serial allowed, 2 ready high, 3 powered down.
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
      if (k > lim) begin
        n_mismatch++;
        summarize();
      end
    end while (!(sel == 0 && data_ready_n === 1'b0 || sel == 1 && status.spi_allowed === 1'b1
      || sel == 2 && data_ready_n === 1'b1 || sel == 3 && status.powered_down === 1'b1));
  endtask
  task automatic send(input acs_cmd_t c);
    @(posedge ref_clk);
    cmd <= '{valid: 1'b1, code: c};
    @(posedge ref_clk);
    cmd.valid <= 1'b0;
  endtask
  task automatic t_resets();
    int lo;
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      if (k == 0) reset_n_pin <= 1'b0;
      else send(ACS_CMD_RESET);
      cyc(5);
      `CHK("regs_reset", 1'b1, status.regs_reset)
      `CHK("clock_sel_internal", 1'b1, status.clock_sel_internal)
      `CHK("spi_allowed", 1'b0, status.spi_allowed)
      if (k == 0) begin
        cyc(40);
        `CHK("spi_allowed", 1'b0, status.spi_allowed)
        @(posedge ref_clk);
        reset_n_pin <= 1'b1;
      end
      // The pin hold is timed from release plus two sync stages; the command from its strobe.
      lo = (k == 0) ? RST : RST - 7;
      wait_for(1, 60, n);
      `CHK("hold window", 1'b1, n >= lo && n <= lo + 4)
    end
  endtask
  task automatic t_single();
    @(posedge ref_clk);
    start_req <= 1'b1;
    cyc(4);
    start_req <= 1'b0;
    cyc(2);
    `CHK("filter_reset", 1'b1, status.filter_reset)
    wait_for(0, T + 20, n);
    `CHK("single time", 1'b1, n >= T - 8 && n <= T + 4)
    `CHK("shared pin", 1'b0, shared)
    cyc(3);
    `CHK("powered_down", 1'b1, status.powered_down)
    cyc(12);
    `CHK("ready stands", 1'b0, data_ready_n)
    cyc(300);
    `CHK("ready released", 1'b1, data_ready_n)
    `CHK("shared idle", 1'b1, shared)
    `CHK("still down", 1'b1, status.powered_down)
  endtask
  task automatic t_continuous();
    int m;
    @(posedge ref_clk);
    slow <= 1'b0;
    start_req <= 1'b1;
    wait_for(0, T + 20, n);
    wait_for(2, 40, m);
    wait_for(0, T + 20, n);
    `CHK("continuous period", T, m + n)
    send(ACS_CMD_SLEEP);
    cyc(2);
    `CHK("sleep", 1'b1, status.powered_down)
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      cfg.reference_control_bits <= 2'(r);
      cfg.ready_on_data_out_select <= r[0];
      cyc(2);
      `CHK("reference_on", r == 1, status.reference_on)
      if (!r[0]) `CHK("shared data", ~data_out_bit, shared)
    end
    send(ACS_CMD_WAKE);
    `CHK("wake hold", 1'b1, status.filter_reset)
    `CHK("wake up", 1'b0, status.powered_down)
    wait_for(0, T + 20, n);
    `CHK("wake time", 1'b1, n >= T - 10 && n <= T + 4)
    @(posedge ref_clk);
    start_req <= 1'b0;
    wait_for(3, T + 40, n);
    `CHK("start low down", 1'b1, status.powered_down)
    `CHK("finish then down", 1'b1, n >= T - 8 && n <= T)
  endtask
  initial begin
    cyc(20);
    srst <= 1'b0;
    wait_for(1, 200, n);
    `CHK("power-on hold", 1'b1, n >= 90 && n <= 100)
    t_resets();
    t_single();
    t_continuous();
    summarize();
  end
endmodule // testbench
